// file: design/cmi_logic_block.sv
// One logic block: macrocells, I/O cells, test port programming and register slave
`timescale 1ns/10ps
`default_nettype none
module cmi_logic_block
    import cmi_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter logic [PASS_BITS-1:0] PASSWORD = 16'h5a3c
) (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Synchronous reset
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [NUM_PT-1:0] prodTerm, // Logic product terms
    input wire logic resetTerm, // Shared reset term
    input wire logic presetTerm, // Shared preset term
    input wire logic [1:0] oeTerm, // Shared enable terms
    input wire logic [1:0] clkPin, // Clock or gate pins
    input wire logic [NUM_PINS-1:0] ioIn, // I/O pin levels
    output logic [NUM_PINS-1:0] ioOut, // I/O pin drive value
    output logic [NUM_PINS-1:0] ioOe, // I/O pin drive enable
    output logic [NUM_CELLS-1:0] feedback, // Cell results to routing
    output logic [1:0] clkData, // Clock pins as data
    input wire logic tck, // Test clock
    input wire logic tms, // Test mode select
    input wire logic tdi, // Test data in
    output logic tdo, // Test data out
    output logic tdoOe // Test data out enable
);
    if (ADDR_W < 8) begin : g_chk
        $error("ADDR_W must be at least 8");
    end

    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [1:0] clkMeta, clkSync, clkPrev;
    logic [NUM_PINS-1:0] pinMeta, pinSync;
    logic [2:0] jtMeta, jtSync;
    logic tckPrev;
    logic [1:0] clkRise;
    logic tckRise, tckFall, tmsS, tdiS;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            clkMeta <= 2'h0;
            clkSync <= 2'h0;
            clkPrev <= 2'h0;
            pinMeta <= '0;
            pinSync <= '0;
            jtMeta <= 3'h0;
            jtSync <= 3'h0;
            tckPrev <= 1'b0;
        end else begin
            clkMeta <= clkPin;
            clkSync <= clkMeta;
            clkPrev <= clkSync;
            pinMeta <= ioIn;
            pinSync <= pinMeta;
            jtMeta <= {tck, tms, tdi};
            jtSync <= jtMeta;
            tckPrev <= jtSync[2];
        end
    end

    assign clkRise = clkSync & ~clkPrev;
    assign tckRise = jtSync[2] & ~tckPrev;
    assign tckFall = ~jtSync[2] & tckPrev;
    assign tmsS = jtSync[1];
    assign tdiS = jtSync[0];

    // ************************************************
    // Test access port
    // ************************************************
    cmi_tap_e tap, next_tap;
    logic [IR_BITS-1:0] ir, irShift;
    logic bypassBit;
    logic [PAT_BITS-1:0] patShift, cfgFlat;
    logic [PASS_BITS-1:0] passShift;
    logic progMode, secure, forceHiZ;
    logic fire, doErase, doProgram, doSecure;
    logic drIsPat, drIsPass;
    cmi_cell_s cfg [NUM_CELLS];

    always_comb begin
        case (tap)
            TAP_RESET: next_tap = tmsS ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: next_tap = tmsS ? SEL_DR : TAP_IDLE;
            SEL_DR: next_tap = tmsS ? SEL_IR : CAP_DR;
            CAP_DR: next_tap = tmsS ? EX1_DR : SH_DR;
            SH_DR: next_tap = tmsS ? EX1_DR : SH_DR;
            EX1_DR: next_tap = tmsS ? UP_DR : PA_DR;
            PA_DR: next_tap = tmsS ? EX2_DR : PA_DR;
            EX2_DR: next_tap = tmsS ? UP_DR : SH_DR;
            UP_DR: next_tap = tmsS ? SEL_DR : TAP_IDLE;
            SEL_IR: next_tap = tmsS ? TAP_RESET : CAP_IR;
            CAP_IR: next_tap = tmsS ? EX1_IR : SH_IR;
            SH_IR: next_tap = tmsS ? EX1_IR : SH_IR;
            EX1_IR: next_tap = tmsS ? UP_IR : PA_IR;
            PA_IR: next_tap = tmsS ? EX2_IR : PA_IR;
            EX2_IR: next_tap = tmsS ? UP_IR : SH_IR;
            UP_IR: next_tap = tmsS ? SEL_DR : TAP_IDLE;
            default: next_tap = TAP_RESET;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tap <= TAP_RESET;
        end else if (tckRise) begin
            tap <= next_tap;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ir <= INS_BYPASS;
            irShift <= IR_CAPTURE;
        end else if (tckRise) begin
            if (tap == TAP_RESET) begin
                ir <= INS_BYPASS;
            end else if (tap == CAP_IR) begin
                irShift <= IR_CAPTURE;
            end else if (tap == SH_IR) begin
                irShift <= {tdiS, irShift[IR_BITS-1:1]};
            end else if (tap == UP_IR) begin
                ir <= irShift;
            end
        end
    end

    assign drIsPat = (ir == INS_LOAD) || (ir == INS_VERIFY);
    assign drIsPass = (ir == INS_ENTER);

    // one-bit bypass path; all codes but LOAD, VERIFY and ENTER act the same
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bypassBit <= 1'b0;
            patShift <= '0;
            passShift <= '0;
        end else if (tckRise) begin
            if (tap == CAP_DR) begin
                bypassBit <= 1'b0;
                if (ir == INS_VERIFY) begin
                    patShift <= secure ? '0 : cfgFlat;
                end
            end else if (tap == SH_DR) begin
                if (drIsPat) begin
                    patShift <= {tdiS, patShift[PAT_BITS-1:1]};
                end else if (drIsPass) begin
                    passShift <= {tdiS, passShift[PASS_BITS-1:1]};
                end else begin
                    bypassBit <= tdiS;
                end
            end
        end
    end

    // Output changes on the falling edge so the next device samples a stable bit
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tdo <= 1'b0;
            tdoOe <= 1'b0;
        end else if (tckFall) begin
            tdoOe <= (tap == SH_IR) || (tap == SH_DR);
            if (tap == SH_IR) begin
                tdo <= irShift[0];
            end else if (drIsPat) begin
                tdo <= patShift[0];
            end else if (drIsPass) begin
                tdo <= passShift[0];
            end else begin
                tdo <= bypassBit;
            end
        end
    end

    // ************************************************
    // Programming control
    // ************************************************
    // actions need protected mode and the matching instruction
    assign fire = tckRise && (tap == TAP_IDLE) && progMode;
    assign doErase = fire && (ir == INS_ERASE);
    assign doProgram = fire && (ir == INS_PROGRAM) && !secure;
    assign doSecure = fire && (ir == INS_SECURE);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            progMode <= 1'b0;
        end else if (tckRise) begin
            if (tap == TAP_RESET) begin
                progMode <= 1'b0;
            end else if (tap == UP_DR && drIsPass && passShift == PASSWORD) begin
                progMode <= 1'b1;
            end else if (tap == UP_IR && irShift == INS_EXIT) begin
                progMode <= 1'b0;
            end
        end
    end

    // security bit; only a bulk erase or reset clears it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            secure <= 1'b0;
        end else if (doErase) begin
            secure <= 1'b0;
        end else if (doSecure) begin
            secure <= 1'b1;
        end
    end

    for (genvar n = 0; n < NUM_CELLS; n++) begin : g_cfg
        assign cfgFlat[n*CFG_BITS +: CFG_BITS] = cfg[n];
        always_ff @(posedge clk_sys) begin
            if (!rst_n || doErase) begin
                cfg[n] <= '0;
            end else if (doProgram) begin
                cfg[n] <= patShift[n*CFG_BITS +: CFG_BITS];
            end
        end
    end

    // ************************************************
    // Macrocells
    // ************************************************
    logic [NUM_CELLS-1:0] sum, q, result;

    for (genvar n = 0; n < NUM_CELLS; n++) begin : g_cell
        localparam bit BURIED = (n % 2) == 1;
        logic [CL_SPAN-1:0] avail;
        logic clkR, gate, pinD, useSum;
        // four clusters of four terms, clipped at the ends
        for (genvar j = 0; j < CL_SPAN; j++) begin : g_cl
            localparam int C = n - 1 + j;
            if (C >= 0 && C < NUM_CELLS) begin : g_in
                assign avail[j] = |prodTerm[C*PT_PER_CL +: PT_PER_CL];
            end else begin : g_out
                assign avail[j] = 1'b0;
            end
        end
        assign sum[n] = |(avail & cfg[n].clusterEn);
        assign clkR = clkRise[cfg[n].clkSel];
        assign gate = clkSync[cfg[n].clkSel];
        assign pinD = BURIED ? pinSync[n/2] : 1'b0;
        // shared terms first; reset beats preset
        always_ff @(posedge clk_sys) begin
            if (!rst_n || resetTerm) begin
                q[n] <= 1'b0;
            end else if (presetTerm) begin
                q[n] <= 1'b1;
            end else begin
                case (cfg[n].mode)
                    // D or T on the rising edge
                    CM_REG: begin
                        if (clkR) begin
                            q[n] <= cfg[n].tType ? (q[n] ^ sum[n]) : sum[n];
                        end
                    end
                    CM_LATCH: begin
                        if (!gate) begin
                            q[n] <= sum[n];
                        end
                    end
                    CM_INPUT: begin
                        if (BURIED && (cfg[n].tType ? !gate : clkR)) begin
                            q[n] <= pinD;
                        end
                    end
                    default: q[n] <= q[n];
                endcase
            end
        end
        // Input mode on an output cell has no pin path, so it stays combinational
        assign useSum = (cfg[n].mode == CM_COMB) || (cfg[n].mode == CM_INPUT && !BURIED);
        assign result[n] = (useSum ? sum[n] : q[n]) ^ cfg[n].invert;
    end

    // every result feeds back; only even cells reach pins
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            feedback <= '0;
            clkData <= 2'h0;
        end else begin
            feedback <= result;
            clkData <= clkSync;
        end
    end

    // ************************************************
    // I/O cells
    // ************************************************
    for (genvar k = 0; k < NUM_PINS; k++) begin : g_io
        cmi_cell_s oc;
        logic en;
        assign oc = cfg[2*k];
        // driver choice with shared enable terms
        always_comb begin
            case (oc.oeMode)
                OE_ON: en = 1'b1;
                OE_PT: en = oeTerm[oc.oeSel];
                default: en = 1'b0;
            endcase
        end
        // output cell drives its pin, never during programming
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                ioOut[k] <= 1'b0;
                ioOe[k] <= 1'b0;
            end else begin
                ioOut[k] <= result[2*k];
                ioOe[k] <= en && !progMode && !forceHiZ;
            end
        end
    end

    // ************************************************
    // Register slave
    // ************************************************
    logic awHeld, wHeld;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic [31:0] rdMux;
    logic rdOk;
    logic [7:0] rAddr;

    assign s_axi_awready = !awHeld;
    assign s_axi_wready = !wHeld;
    assign s_axi_arready = !s_axi_rvalid;
    assign rAddr = s_axi_araddr[7:0];

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= 8'h00;
            wData <= 32'h0;
            wStrb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            forceHiZ <= CTRL_HIZ_RESET;
        end else begin
            if (s_axi_awvalid && !awHeld) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && !wHeld) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (awHeld && wHeld && !s_axi_bvalid) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= RESP_OKAY;
                if (awAddr == ADDR_CTRL) begin
                    if (wStrb[0]) begin
                        forceHiZ <= wData[CTRL_HIZ];
                    end
                end else if (awAddr != ADDR_STATUS && awAddr != ADDR_FBK && awAddr[7:6] != 2'b01) begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        rdMux = 32'h0;
        rdOk = 1'b1;
        if (rAddr == ADDR_CTRL) begin
            rdMux[CTRL_HIZ] = forceHiZ;
        end else if (rAddr == ADDR_STATUS) begin
            rdMux[ST_PROG] = progMode;
            rdMux[ST_SECURE] = secure;
            rdMux[ST_TAP +: 4] = tap;
            rdMux[ST_IR +: IR_BITS] = ir;
        end else if (rAddr == ADDR_FBK) begin
            rdMux[NUM_CELLS-1:0] = feedback;
        end else if (rAddr[7:6] == ADDR_CFG[7:6] && rAddr[1:0] == 2'h0) begin
            rdMux[CFG_BITS-1:0] = cfg[rAddr[5:2]];
        end else begin
            rdOk = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence secureProgram;
        secure && tckRise && tap == TAP_IDLE && progMode && ir == INS_PROGRAM;
    endsequence

    a_prog_hiz_out: assert property ($past(progMode) |-> ioOe == '0)
        else $error("pin driven during programming");
    a_secure_blocks_prog: assert property (secureProgram |=> $stable(cfgFlat))
        else $error("secured pattern changed");
    a_cfg_guard: assert property ($changed(cfgFlat) |-> $past(progMode)
        && ($past(ir) == INS_ERASE || $past(ir) == INS_PROGRAM))
        else $error("pattern changed outside programming");
    a_reset_term_clears: assert property (resetTerm |=> q == '0)
        else $error("reset term did not clear storage");
    a_preset_term_sets: assert property (presetTerm && !resetTerm |=> q == '1)
        else $error("preset term did not set storage");
    a_bypass_capture: assert property (tckRise && tap == CAP_DR |=> !bypassBit)
        else $error("bypass bit not cleared at capture");
    a_oe_off_mode: assert property (cfg[0].oeMode == OE_OFF |=> !ioOe[0])
        else $error("disabled driver enabled");
    a_reg_hold: assert property (cfg[1].mode == CM_REG && !resetTerm && !presetTerm
        && !clkRise[cfg[1].clkSel] |=> $stable(q[1]))
        else $error("register changed without clock edge");
    a_latch_hold: assert property (cfg[3].mode == CM_LATCH && !resetTerm && !presetTerm
        && clkSync[cfg[3].clkSel] |=> $stable(q[3]))
        else $error("latch changed while gate high");
endmodule
`default_nettype wire

// file: design/cmi_pkg.sv
// Constants, encodings and types of the macrocell, I/O and programming block
package cmi_pkg;
    localparam int NUM_CELLS = 16;
    localparam int NUM_PINS = 8;
    localparam int NUM_PT = 64;
    localparam int PT_PER_CL = 4;
    localparam int CL_SPAN = 4;
    localparam int CFG_BITS = 12;
    localparam int PAT_BITS = NUM_CELLS * CFG_BITS;
    localparam int IR_BITS = 4;
    localparam int PASS_BITS = 16;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_FBK = 8'h08;
    localparam logic [7:0] ADDR_CFG = 8'h40;
    localparam int CTRL_HIZ = 0;
    localparam logic CTRL_HIZ_RESET = 1'h0;
    localparam int ST_PROG = 0;
    localparam int ST_SECURE = 1;
    localparam int ST_TAP = 4;
    localparam int ST_IR = 8;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0] INS_ENTER = 4'h2;
    localparam logic [3:0] INS_EXIT = 4'h3;
    localparam logic [3:0] INS_ERASE = 4'h4;
    localparam logic [3:0] INS_LOAD = 4'h5;
    localparam logic [3:0] INS_PROGRAM = 4'h6;
    localparam logic [3:0] INS_VERIFY = 4'h7;
    localparam logic [3:0] INS_SECURE = 4'h8;
    localparam logic [3:0] INS_BYPASS = 4'hf;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CM_COMB = 2'b00,
        CM_REG = 2'b01,
        CM_LATCH = 2'b10,
        CM_INPUT = 2'b11
    } cmi_mode_e;

    typedef enum logic [1:0] {
        OE_OFF = 2'b00,
        OE_ON = 2'b01,
        OE_PT = 2'b10,
        OE_RSV = 2'b11
    } cmi_oe_e;

    typedef struct packed {
        logic [3:0] clusterEn;
        logic oeSel;
        cmi_oe_e oeMode;
        logic clkSel;
        logic invert;
        logic tType;
        cmi_mode_e mode;
    } cmi_cell_s;

    typedef enum logic [3:0] {
        TAP_RESET = 4'b0000, TAP_IDLE = 4'b0001, SEL_DR = 4'b0010, CAP_DR = 4'b0011,
        SH_DR = 4'b0100, EX1_DR = 4'b0101, PA_DR = 4'b0110, EX2_DR = 4'b0111,
        UP_DR = 4'b1000, SEL_IR = 4'b1001, CAP_IR = 4'b1010, SH_IR = 4'b1011,
        EX1_IR = 4'b1100, PA_IR = 4'b1101, EX2_IR = 4'b1110, UP_IR = 4'b1111
    } cmi_tap_e;
endpackage

// file: testbench/cmi_jtag_model.sv
// Programming controller model driving the test port of the logic block
`timescale 1ns/10ps
`default_nettype none
module cmi_jtag_model
    import cmi_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic tdo, // Test data out
    output logic tck, // Test clock
    output logic tms, // Test mode select
    output logic tdi // Test data in
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one 800 ns test clock, low between frames
    task automatic step(input logic m, input logic d, output logic q);
        tms <= m;
        tdi <= d;
        repeat (5) @(posedge clk_sys);
        q = tdo;
        tck <= 1'b1;
        repeat (3) @(posedge clk_sys);
        tck <= 1'b0;
    endtask
    // scan from idle: n entry clocks, shift LSB first, update, idle
    task automatic walk(input int n, input int bits, input logic [PAT_BITS-1:0] v,
                        output logic [PAT_BITS-1:0] got);
        logic q;
        got = '0;
        for (int i = 0; i < n; i++) begin
            step(i < n - 2, 1'b0, q);
        end
        for (int i = 0; i < bits; i++) begin
            step(i == bits - 1, v[i], got[i]);
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask
endmodule
`default_nettype wire

// file: testbench/test_cmi_logic_block.sv
// Self-checking bench of the logic block
`timescale 1ns/10ps
`default_nettype none
module test_cmi_logic_block
    import cmi_pkg::*;
;
    typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] r;} cmi_row_s;
    localparam logic [PASS_BITS-1:0] PWD = 16'h5a3c;
    localparam cmi_cell_s CELL = '{4'h0, 1'b0, OE_ON, 1'b0, 1'b1, 1'b0, CM_COMB};
    // Cell 1 a D register, cell 3 a latch, so the hold checks have work to do
    localparam logic [PAT_BITS-1:0] PAT = PAT_BITS'({12'h002, 12'h000, 12'h001, CELL});
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awAddr = '0, arAddr = '0, ioOut, ioOe;
    logic [31:0] wData = '0, rData;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic awReady, wReady, bValid, arReady, rValid, tck, tms, tdi, tdo;
    logic [1:0] bResp, rResp, pins = '0;
    logic [63:0] pt = '0;
    logic rstTerm = 1'b0, setTerm = 1'b0;
    int failCount = 0, comparisons = 0;
    cmi_row_s rows [10] = '{'{0, ADDR_CTRL, 0, RESP_OKAY}, '{0, ADDR_STATUS, 32'hf00, RESP_OKAY},
        '{0, ADDR_FBK, 0, RESP_OKAY}, '{0, 8'h7c, 0, RESP_OKAY}, '{0, 8'h0c, 0, RESP_SLVERR},
        '{0, 8'h80, 0, RESP_SLVERR}, '{1, 8'h0c, 1, RESP_SLVERR}, '{1, ADDR_STATUS, 3, RESP_OKAY},
        '{0, ADDR_STATUS, 32'hf00, RESP_OKAY}, '{1, ADDR_CTRL, 0, RESP_OKAY}};
    always #50 clk_sys = ~clk_sys;
    cmi_logic_block #(.PASSWORD(PWD)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .prodTerm(pt), .resetTerm(rstTerm), .presetTerm(setTerm), .oeTerm(pins), .clkPin(pins), .ioIn(8'h00),
        .ioOut(ioOut), .ioOe(ioOe), .feedback(), .clkData(), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdoOe());
    cmi_jtag_model ctrl (.clk_sys(clk_sys), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failCount++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic endSim;
        $display("comparisons %0d mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n = 0;
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
        end while (!bValid && n < 50);
        if (!bValid) failCount++;
        r = bResp;
        bReady <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (arReady) arValid <= 1'b0;
        end while (!rValid && n < 50);
        if (!rValid) failCount++;
        d = rData;
        r = rResp;
        rReady <= 1'b0;
        @(posedge clk_sys);
    endtask
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic q;
        logic [PAT_BITS-1:0] g;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        foreach (rows[i]) begin
            d = rows[i].d;
            if (rows[i].wr) axiWr(rows[i].a, rows[i].d, r);
            else axiRd(rows[i].a, d, r);
            check("data", d, rows[i].d);
            check("resp", {30'h0, r}, {30'h0, rows[i].r});
        end
        $display("register test done");
        ctrl.step(1'b0, 1'b0, q);
        ctrl.walk(4, IR_BITS, INS_BYPASS, g);
        check("irCapture", g[31:0], 32'(IR_CAPTURE));
        ctrl.walk(3, 4, 'hb, g);
        check("bypass", g[31:0], 32'h6);
        ctrl.walk(4, IR_BITS, INS_ENTER, g);
        ctrl.walk(3, PASS_BITS, PWD, g);
        axiRd(ADDR_STATUS, d, r);
        check("progMode", {31'h0, d[0]}, 1);
        ctrl.walk(4, IR_BITS, INS_ERASE, g);
        ctrl.walk(4, IR_BITS, INS_LOAD, g);
        ctrl.walk(3, PAT_BITS, PAT, g);
        ctrl.walk(4, IR_BITS, INS_PROGRAM, g);
        check("hiZ", {24'h0, ioOe}, 0);
        axiRd(ADDR_CFG, d, r);
        check("cfg0", d, 32'(CELL));
        ctrl.walk(4, IR_BITS, INS_VERIFY, g);
        ctrl.walk(3, 16, '0, g);
        check("verify", g[31:0], 32'(PAT[15:0]));
        ctrl.walk(4, IR_BITS, INS_SECURE, g);
        ctrl.walk(4, IR_BITS, INS_LOAD, g);
        ctrl.walk(3, PAT_BITS, '0, g);
        ctrl.walk(4, IR_BITS, INS_PROGRAM, g);
        ctrl.walk(4, IR_BITS, INS_VERIFY, g);
        ctrl.walk(3, 16, '0, g);
        check("secured", g[31:0], 0);
        ctrl.walk(4, IR_BITS, INS_EXIT, g);
        check("pin0", {30'h0, ioOe[0], ioOut[0]}, 3);
        ctrl.walk(4, IR_BITS, INS_ERASE, g);
        axiRd(ADDR_CFG, d, r);
        check("noErase", d, 32'(CELL));
        axiRd(ADDR_STATUS, d, r);
        check("status", {30'h0, d[1:0]}, 2);
        $display("programming test done");
        pins <= 2'h3;
        repeat (4) @(posedge clk_sys);
        setTerm <= 1'b1;
        @(posedge clk_sys);
        setTerm <= 1'b0;
        repeat (2) @(posedge clk_sys);
        axiRd(ADDR_FBK, d, r);
        check("presetFbk", d, 32'hb);
        rstTerm <= 1'b1;
        @(posedge clk_sys);
        rstTerm <= 1'b0;
        repeat (2) @(posedge clk_sys);
        axiRd(ADDR_FBK, d, r);
        check("resetFbk", d, 32'h1);
        pins <= 2'h0;
        $display("term test done");
        endSim();
    end
    initial begin
        repeat (30000) @(posedge clk_sys);
        failCount++;
        $display("mismatch watchdog expected done seen timeout");
        endSim();
    end
endmodule
`default_nettype wire
